// >>> adcc_pkg.sv
// package: register map, fields and timing constants of the converter control
`default_nettype none
package adcc_pkg;
	// register word offsets on the bus
	localparam logic [3:0] CONTROL_OFS  = 4'h0;
	localparam logic [3:0] POSSEL_OFS   = 4'h1;
	localparam logic [3:0] NEGSEL_OFS   = 4'h2;
	localparam logic [3:0] STATUS_OFS   = 4'h3;
	localparam logic [3:0] RESULT_OFS   = 4'h4;
	localparam logic [3:0] GAIN_OFS     = 4'h5;
	// control field positions, then the code position in the result word
	localparam int POS_BYP_BIT  = 15;
	localparam int NEG_BYP_BIT  = 14;
	localparam int CLKDIV_LSB   = 11;
	localparam int ACQ_LSB      = 8;
	localparam int ENABLE_BIT   = 7;
	localparam int POWER_BIT    = 5;
	localparam int MODE_LSB     = 3;
	localparam int RESULT_LSB   = 16;
	// reset values
	localparam logic [15:0] CONTROL_RST = 16'h0A00;
	localparam logic [4:0]  GAIN_RST    = 5'h00;
	// conversion core cycles beyond acquisition
	localparam logic [7:0]  CONV_CLOCKS = 8'h13;
	// mode encodings
	typedef enum logic [1:0]
	{
		MODE_SINGLE = 2'b00,
		MODE_DIFF   = 2'b01,
		MODE_PSEUDO = 2'b10,
		MODE_RSVD   = 2'b11
	} adcc_mode_type;
	// trigger source encodings
	typedef enum logic [2:0]
	{
		TRIG_PIN   = 3'b000,
		TRIG_TMR1  = 3'b001,
		TRIG_TMR0  = 3'b010,
		TRIG_SWONE = 3'b011,
		TRIG_SWCON = 3'b100,
		TRIG_LOGIC = 3'b101,
		TRIG_PWM   = 3'b110,
		TRIG_RSVD  = 3'b111
	} adcc_trig_type;
	// sequencer states, gray along idle-acquire-convert
	typedef enum logic [1:0]
	{
		ST_IDLE    = 2'b00,
		ST_ACQUIRE = 2'b01,
		ST_CONVERT = 2'b11,
		ST_FINISH  = 2'b10
	} adcc_state_type;
endpackage : adcc_pkg
`default_nettype wire

// >>> adcc_clkdiv.sv
// converter clock enable generator: divide core clock by 1..32
`default_nettype none
module adcc_clkdiv
	import adcc_pkg::*;
(
	// system
	input  wire logic       clk,
	input  wire logic       rst,
	// divider select and enable tick
	input  wire logic [2:0] divSel,
	output logic            tick
);
	typedef struct packed
	{
		logic [4:0] cnt;
		logic       tick;
	} adcc_div_type;
	adcc_div_type s_q;
	adcc_div_type s_d;
	logic [4:0] lim;

	///////////////////////////////////////////////////////////////////////
	// terminal count; codes above 5 saturate at divide-by-32
	always_comb
	begin
		lim = (divSel > 3'h5) ? 5'h1F : 5'((6'h01 << divSel) - 6'h01);
		s_d = s_q;
		s_d.tick = (s_q.cnt >= lim);
		s_d.cnt = s_d.tick ? 5'h00 : 5'(s_q.cnt + 5'h01);
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign tick = s_q.tick;
endmodule // adcc_clkdiv
`default_nettype wire

// >>> adcc_format.sv
// result formatter: straight binary or shifted two's complement word
`default_nettype none
module adcc_format
	import adcc_pkg::*;
(
	// system
	input  wire logic        clk,
	input  wire logic        rst,
	// raw code and mode
	input  wire logic        load,
	input  wire logic [11:0] rawCode,
	input  wire logic [1:0]  mode,
	// formatted word
	output logic [31:0]      word
);
	typedef struct packed
	{
		logic [31:0] word;
	} adcc_fmt_type;
	adcc_fmt_type s_q;
	adcc_fmt_type s_d;
	logic [11:0] signedCode;

	///////////////////////////////////////////////////////////////////////
	// differential: offset code to two's complement, then arithmetic >>1
	always_comb
	begin
		signedCode = rawCode ^ 12'h800;
		s_d = s_q;
		if (load)
		begin
			if (mode == MODE_DIFF)
				s_d.word = {{5{signedCode[11]}}, signedCode[11:1],
					16'h0000};
			else
				s_d.word = {4'h0, rawCode, 16'h0000};
		end
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign word = s_q.word;
endmodule // adcc_format
`default_nettype wire

// >>> adcc_top.sv
// converter control: register slave, trigger select, sequencer, analog cfg
//
// Our own choices: the register addresses and the Avalon-MM slave port.
`default_nettype none
module adcc_top
	import adcc_pkg::*;
(
	// system
	input  wire logic        clk,
	input  wire logic        rst,
	// avalon-mm slave
	input  wire logic [3:0]  address,
	input  wire logic        read,
	input  wire logic        write,
	input  wire logic [31:0] writedata,
	output logic [31:0]      readdata,
	output logic             waitrequest,
	// trigger sources
	input  wire logic        convStartPin,
	input  wire logic        logicArrayTrig,
	input  wire logic        timer0Ovf,
	input  wire logic        timer1Ovf,
	input  wire logic        pwmTrig,
	// successive approximation core result
	input  wire logic [11:0] sarCode,
	// analog front-end controls
	output logic [4:0]       posChannel,
	output logic [4:0]       negChannel,
	output logic [4:0]       amplifierGain,
	output logic             posBufferBypass,
	output logic             negBufferBypass,
	output logic [1:0]       inputMode,
	output logic             powerUp,
	output logic             sampleHold,
	// status
	output logic             convertingIndicator,
	output logic             conversionDone
);
	typedef struct packed
	{
		logic [15:0]    ctrl;
		logic [4:0]     posSel;
		logic [4:0]     negSel;
		logic [4:0]     gain;
		logic           ready;
		logic [7:0]     cnt;
		adcc_state_type state;
		logic           trigPrev;
		logic [31:0]    rdata;
		logic           ack;
		logic           busy;
		logic           done;
		logic           hold;
	} adcc_top_type;
	adcc_top_type s_q;
	adcc_top_type s_d;

	logic        tick;
	logic [31:0] resultWord;
	logic        trigLevel;
	logic        trigStart;
	logic        swStart;
	logic        access;
	logic [7:0]  acqClocks;
	logic        finishing;

	// one clock domain: every assertion below shares this clock and reset
	default clocking adccCb @(posedge clk);
	endclocking
	default disable iff (rst);

	///////////////////////////////////////////////////////////////////////
	// converter clock divider and result formatter
	adcc_clkdiv u_div
	(
		.clk    (clk),
		.rst    (rst),
		.divSel (s_q.ctrl[CLKDIV_LSB +: 3]),
		.tick   (tick)
	);

	adcc_format u_fmt
	(
		.clk     (clk),
		.rst     (rst),
		.load    (finishing),
		.rawCode (sarCode),
		.mode    (s_q.ctrl[MODE_LSB +: 2]),
		.word    (resultWord)
	);

	///////////////////////////////////////////////////////////////////////
	// acquisition clocks: 2 << code, codes above 5 held at 64
	always_comb
	begin
		if (s_q.ctrl[ACQ_LSB +: 3] > 3'h5)
			acqClocks = 8'h40;
		else
			acqClocks = 8'((9'h002 << s_q.ctrl[ACQ_LSB +: 3]));
	end

	// hardware trigger level chosen by the conversion type field
	always_comb
	begin
		case (adcc_trig_type'(s_q.ctrl[2:0]))
			TRIG_PIN:   trigLevel = convStartPin;
			TRIG_TMR1:  trigLevel = timer1Ovf;
			TRIG_TMR0:  trigLevel = timer0Ovf;
			TRIG_LOGIC: trigLevel = logicArrayTrig;
			TRIG_PWM:   trigLevel = pwmTrig;
			default:    trigLevel = 1'b0;
		endcase
	end

	assign trigStart = trigLevel && !s_q.trigPrev;
	assign swStart = (s_q.ctrl[2:0] == TRIG_SWONE)
		|| (s_q.ctrl[2:0] == TRIG_SWCON);
	assign access = (read || write) && !s_q.ack;
	assign finishing = (s_q.state == ST_CONVERT) && tick && (s_q.cnt == 8'h01);

	///////////////////////////////////////////////////////////////////////
	// next state: bus slave, sequencer, status
	always_comb
	begin
		s_d = s_q;
		s_d.ack = access;
		s_d.done = 1'b0;
		s_d.trigPrev = trigLevel;
		// bus write; one wait state, taken when ack goes high
		if (write && s_q.ack)
		begin
			case (address)
				CONTROL_OFS: s_d.ctrl = writedata[15:0];
				POSSEL_OFS:  s_d.posSel = writedata[4:0];
				NEGSEL_OFS:  s_d.negSel = writedata[4:0];
				GAIN_OFS:    s_d.gain = writedata[4:0];
				default:     s_d.ctrl = s_d.ctrl;
			endcase
		end
		// bus read data, registered in the wait cycle
		if (read && !s_q.ack)
		begin
			case (address)
				CONTROL_OFS: s_d.rdata = {16'h0000, s_q.ctrl};
				POSSEL_OFS:  s_d.rdata = {27'h0, s_q.posSel};
				NEGSEL_OFS:  s_d.rdata = {27'h0, s_q.negSel};
				STATUS_OFS:  s_d.rdata = {31'h0, s_q.ready};
				RESULT_OFS:  s_d.rdata = resultWord;
				GAIN_OFS:    s_d.rdata = {27'h0, s_q.gain};
				default:     s_d.rdata = 32'h0000_0000;
			endcase
		end
		// result read clears ready; a new result in same cycle wins
		if (read && s_q.ack && address == RESULT_OFS)
			s_d.ready = 1'b0;
		// sequencer; acquire and convert counts stepped on converter clock ticks
		case (s_q.state)
			ST_IDLE:
			begin
				if (s_q.ctrl[ENABLE_BIT] && s_q.ctrl[POWER_BIT]
					&& (swStart || trigStart))
				begin
					s_d.state = ST_ACQUIRE;
					s_d.cnt = acqClocks;
					s_d.busy = 1'b1;
					s_d.hold = 1'b0;
				end
			end
			ST_ACQUIRE:
			begin
				if (tick)
				begin
					s_d.cnt = 8'(s_q.cnt - 8'h01);
					if (s_q.cnt == 8'h01)
					begin
						s_d.state = ST_CONVERT;
						s_d.cnt = CONV_CLOCKS;
						s_d.hold = 1'b1;
					end
				end
			end
			ST_CONVERT:
			begin
				if (tick)
				begin
					s_d.cnt = 8'(s_q.cnt - 8'h01);
					if (s_q.cnt == 8'h01)
					begin
						s_d.state = ST_FINISH;
						s_d.hold = 1'b0;
					end
				end
			end
			ST_FINISH:
			begin
				s_d.ready = 1'b1;
				s_d.done = 1'b1;
				s_d.hold = 1'b0;
				if (s_q.ctrl[2:0] == TRIG_SWONE)
					s_d.ctrl[2:0] = TRIG_PIN;
				// still-asserted trigger or continuous mode reruns
				if (s_q.ctrl[ENABLE_BIT] && s_q.ctrl[POWER_BIT]
					&& (trigLevel || s_q.ctrl[2:0] == TRIG_SWCON))
				begin
					s_d.state = ST_ACQUIRE;
					s_d.cnt = acqClocks;
				end
				else
				begin
					s_d.state = ST_IDLE;
					s_d.busy = 1'b0;
				end
			end
			default:
			begin
				s_d.state = ST_IDLE;
				s_d.busy = 1'b0;
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			s_q <= '0;
			s_q.ctrl <= CONTROL_RST;
			s_q.gain <= GAIN_RST;
			s_q.state <= ST_IDLE;
		end
		else
			s_q <= s_d;
	end

	///////////////////////////////////////////////////////////////////////
	// outputs, all from flops; amplifier has no bypass field
	assign readdata = s_q.rdata;
	assign waitrequest = !s_q.ack;
	assign posChannel = s_q.posSel;
	assign negChannel = s_q.negSel;
	assign amplifierGain = s_q.gain;
	assign posBufferBypass = s_q.ctrl[POS_BYP_BIT];
	assign negBufferBypass = s_q.ctrl[NEG_BYP_BIT];
	assign inputMode = s_q.ctrl[MODE_LSB +: 2];
	assign powerUp = s_q.ctrl[POWER_BIT];
	assign sampleHold = s_q.hold;
	assign convertingIndicator = s_q.busy;
	assign conversionDone = s_q.done;

	///////////////////////////////////////////////////////////////////////
	// assertions: sequencer and busy level
	AST_BUSY_FINISH: assert property
		(s_q.state == ST_FINISH |-> convertingIndicator)
		else $error("busy low at finish");
	AST_IDLE_BUSY: assert property
		(s_q.state == ST_IDLE |-> !convertingIndicator)
		else $error("busy while idle");
	AST_STOP: assert property
		(s_q.state == ST_FINISH && !s_q.ctrl[ENABLE_BIT]
		|=> s_q.state == ST_IDLE && !convertingIndicator)
		else $error("disabled sequencer not stopped");
	AST_FINISH_ONE: assert property
		(s_q.state == ST_FINISH |=> s_q.state != ST_FINISH)
		else $error("finish state held");
	AST_SW_START: assert property
		(s_q.state == ST_IDLE && s_q.ctrl[ENABLE_BIT] && s_q.ctrl[POWER_BIT]
		&& swStart |=> s_q.state == ST_ACQUIRE && convertingIndicator)
		else $error("software start ignored");
	AST_SW_REVERT: assert property
		(s_q.state == ST_FINISH && s_q.ctrl[2:0] == TRIG_SWONE
		|=> s_q.ctrl[2:0] == TRIG_PIN)
		else $error("single software type not reverted");
	AST_HW_START: assert property
		(s_q.state == ST_IDLE && s_q.ctrl[ENABLE_BIT] && s_q.ctrl[POWER_BIT]
		&& trigStart |=> s_q.state == ST_ACQUIRE)
		else $error("trigger edge ignored");
	AST_RERUN: assert property
		(s_q.state == ST_FINISH && trigLevel && s_q.ctrl[7] && s_q.ctrl[5]
		|=> s_q.state == ST_ACQUIRE)
		else $error("no rerun on held trigger");

	// assertions: ready flag, timing counts, result format
	AST_READY_SET: assert property
		(conversionDone |-> s_q.ready)
		else $error("ready not set at end");
	AST_READY_CLR: assert property
		(read && !waitrequest && address == RESULT_OFS && !conversionDone
		&& s_q.state != ST_FINISH |=> !s_q.ready)
		else $error("ready not cleared by read");
	AST_DONE_PULSE: assert property
		(conversionDone |=> !conversionDone)
		else $error("done pulse too long");
	AST_CONV_LEN: assert property
		($rose(sampleHold) |-> s_q.cnt == CONV_CLOCKS)
		else $error("conversion length wrong");
	AST_HOLD_CONV: assert property
		(sampleHold |-> s_q.state == ST_CONVERT)
		else $error("hold outside convert phase");
	AST_ACQ_CNT: assert property
		(s_q.state == ST_ACQUIRE |-> s_q.cnt != 8'h00)
		else $error("acquisition count ran out");
	AST_FMT_BIN: assert property
		(conversionDone && inputMode != MODE_DIFF
		|-> resultWord[31:28] == 4'h0)
		else $error("binary sign field not zero");
	AST_FMT_SGN: assert property
		(conversionDone && $past(inputMode) == MODE_DIFF
		|-> resultWord[31:27] == {5{resultWord[27]}})
		else $error("signed field not extended");

	// assertions: bus answer after one wait state, standing one cycle
	AST_WAIT: assert property
		((read || write) && waitrequest |=> !waitrequest)
		else $error("bus answer late");
	AST_ACK_ONE: assert property
		(!waitrequest |=> waitrequest)
		else $error("bus answer held");

	// covers: main conversion scenarios
	CVR_ONE: cover property (conversionDone && inputMode == MODE_SINGLE);
	CVR_DIFF: cover property (conversionDone && inputMode == MODE_DIFF);
	CVR_PSEUDO: cover property (conversionDone && inputMode == MODE_PSEUDO);
	CVR_HW: cover property (s_q.state == ST_IDLE && trigStart);
	CVR_RERUN: cover property
		(s_q.state == ST_FINISH ##1 s_q.state == ST_ACQUIRE);
endmodule // adcc_top
`default_nettype wire

// >>> adcc_sar_model.sv
// far-side model: code source standing in for the analog core
`default_nettype none
module adcc_sar_model
(
	// system
	input  wire logic        clk,
	input  wire logic        rst,
	// conversion window and code to present
	input  wire logic        busy,
	input  wire logic [11:0] nextCode,
	output logic [11:0]      sarCode
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [11:0] held_q;
	logic [11:0] junk_q;
	// code frozen only while converting; junk outside so stale use shows
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			held_q <= 12'h000;
			junk_q <= 12'h5A5;
		end
		else
		begin
			if (!busy)
				held_q <= nextCode;
			junk_q <= ~junk_q + 12'h001;
		end
	end
	assign sarCode = busy ? held_q : junk_q;
endmodule // adcc_sar_model
`default_nettype wire

// >>> adcc_top_tb_top.sv
// testbench: converter control against a queue-based reference
`default_nettype none
module adcc_top_tb_top import adcc_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clk;
	logic        rst;
	logic [3:0]  address;
	logic        read;
	logic        write;
	logic [31:0] writedata;
	logic [31:0] readdata;
	logic        waitrequest;
	logic [4:0]  trig;
	logic [11:0] sarCode;
	logic [11:0] nextCode;
	logic [4:0]  posChannel;
	logic [4:0]  negChannel;
	logic [4:0]  amplifierGain;
	logic        posBufferBypass;
	logic        negBufferBypass;
	logic [1:0]  inputMode;
	logic        powerUp;
	logic        sampleHold;
	logic        busy;
	logic        done;
	int          failures;
	int          checkCount;
	int          doneCnt;
	int          busyCnt;
	int          holdCnt;
	int          cyc;
	int          seed;
	int          t;
	int          typs[5] = '{0, 1, 2, 5, 6};
	logic [31:0] rd;
	logic [31:0] cfgv;
	logic [31:0] expQ[$];

	adcc_top i_dut
	(
		.clk(clk), .rst(rst), .address(address), .read(read),
		.write(write), .writedata(writedata), .readdata(readdata),
		.waitrequest(waitrequest), .convStartPin(trig[0]),
		.timer1Ovf(trig[1]), .timer0Ovf(trig[2]),
		.logicArrayTrig(trig[3]), .pwmTrig(trig[4]), .sarCode(sarCode),
		.posChannel(posChannel), .negChannel(negChannel),
		.amplifierGain(amplifierGain), .posBufferBypass(posBufferBypass),
		.negBufferBypass(negBufferBypass), .inputMode(inputMode),
		.powerUp(powerUp), .sampleHold(sampleHold),
		.convertingIndicator(busy), .conversionDone(done)
	);
	adcc_sar_model i_model
	(
		.clk(clk), .rst(rst), .busy(busy), .nextCode(nextCode),
		.sarCode(sarCode)
	);

	////////////////////////////////////////////////////////////////////////
	// clock, event counters and hang guard
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc++;
		if (busy === 1'b1) busyCnt++;
		if (sampleHold === 1'b1) holdCnt++;
		if (done === 1'b1) doneCnt++;
		if (cyc == 20000)
		begin
			failures++;
			end_sim();
		end
	end

	////////////////////////////////////////////////////////////////////////
	// reference, compare and bus tasks
	function automatic logic [31:0] expWord(input int m, input logic [11:0] c);
		logic signed [11:0] v;
		// differential: offset code to signed, halved
		v = $signed(c ^ 12'h800) >>> 1;
		if (m == 1)
			return {{4{v[11]}}, v, 16'h0000};
		return {4'h0, c, 16'h0000};
	endfunction
	function automatic logic [31:0] ctl(input int byp, m, typ, dv, aq);
		return 32'((byp << 14) | (dv << 11) | (aq << 8) | 32'h00A0 | (m << 3) | typ);
	endfunction
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		checkCount++;
		if (got !== exp)
		begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// request held until waitrequest seen low, then released
	// no limit of its own: only the cycle ceiling ends a hung wait
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		address <= a;
		write <= wr;
		read <= !wr;
		writedata <= d;
		@(posedge clk);
		while (waitrequest !== 1'b0)
			@(posedge clk);
		rd = readdata;
		read <= 1'b0;
		write <= 1'b0;
		@(posedge clk);
	endtask
	task automatic wait_done(input int target);
		while (doneCnt < target)
			@(posedge clk);
		@(posedge clk);
	endtask
	// one software conversion, busy length bounded by lo..hi cycles
	task automatic conv(input int byp, m, input logic [11:0] c,
		input int dv, aq, lo, hi);
		int tg;
		tg = doneCnt + 1;
		nextCode <= c;
		expQ.push_back(expWord(m, c));
		busyCnt = 0;
		holdCnt = 0;
		bus(1'b1, CONTROL_OFS, ctl(byp, m, 3, dv, aq));
		wait_done(tg);
		cmp(32'(busyCnt >= lo && busyCnt <= hi), 32'h0000_0001);
		cmp(32'(holdCnt), 32'(CONV_CLOCKS) << dv);
		bus(1'b0, STATUS_OFS, 32'h0000_0000);
		cmp(rd & 32'h0000_0001, 32'h0000_0001);
		bus(1'b0, RESULT_OFS, 32'h0000_0000);
		cmp(rd, expQ.pop_front());
		bus(1'b0, STATUS_OFS, 32'h0000_0000);
		cmp(rd & 32'h0000_0001, 32'h0000_0000);
		bus(1'b0, CONTROL_OFS, 32'h0000_0000);
		cmp(rd & 32'h0000_0007, 32'h0000_0000);
	endtask
	task automatic end_sim();
		$display("checks %0d mismatches %0d", checkCount, failures);
		if (failures == 0 && checkCount > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////
	// main sequence
	initial
	begin
		seed = 77825;
		rst = 1'b1;
		address = 4'h0;
		read = 1'b0;
		write = 1'b0;
		writedata = 32'h0000_0000;
		trig = 5'h00;
		nextCode = 12'h000;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		// reset values, read-only status, unmapped hole
		bus(1'b0, CONTROL_OFS, 32'h0000_0000);
		cmp(rd, 32'h0000_0A00);
		cmp(32'(powerUp), 32'h0000_0000);
		bus(1'b1, STATUS_OFS, 32'hFFFF_FFFF);
		bus(1'b0, STATUS_OFS, 32'h0000_0000);
		cmp(rd, 32'h0000_0000);
		bus(1'b0, 4'hE, 32'h0000_0000);
		cmp(rd, 32'h0000_0000);
		$display("test reset done");
		// bypass and mode apart from channel and gain settings
		for (int i = 0; i < 4; i++)
		begin
			cfgv = $random(seed);
			bus(1'b1, POSSEL_OFS, 32'(cfgv[4:0]));
			bus(1'b1, NEGSEL_OFS, 32'(cfgv[9:5]));
			bus(1'b1, GAIN_OFS, 32'(cfgv[14:10]));
			bus(1'b1, CONTROL_OFS, ctl(i, i % 3, 0, 0, 0));
			cmp(32'({posBufferBypass, negBufferBypass}), 32'(i));
			cmp(32'({amplifierGain, negChannel, posChannel}), 32'(cfgv[14:0]));
			cmp(32'(inputMode), 32'(i % 3));
			cmp(32'(powerUp), 32'h0000_0001);
			bus(1'b0, GAIN_OFS, 32'h0000_0000);
			cmp(rd, 32'(cfgv[14:10]));
		end
		$display("test config done");
		// default timing, then each mode at the fastest clock
		// amplified pair: channels and gain first, then pseudo mode and start
		bus(1'b1, POSSEL_OFS, 32'h0000_0001);
		bus(1'b1, NEGSEL_OFS, 32'h0000_0001);
		bus(1'b1, GAIN_OFS, 32'(cfgv[19:15]));
		conv(0, 2, 12'($random(seed)), 1, 2, 54, 58);
		for (int m = 0; m < 3; m++)
			conv(0, m, 12'($random(seed)), 0, 0, 21, 24);
		conv(0, 1, 12'h000, 0, 0, 21, 24);
		conv(0, 1, 12'hFFF, 0, 0, 21, 24);
		// thermistor style: negative buffer bypassed, pseudo mode
		conv(1, 2, 12'($random(seed)), 0, 0, 21, 24);
		// supply monitor channel converted with both buffers on
		bus(1'b1, POSSEL_OFS, 32'h0000_0013);
		conv(0, 0, 12'($random(seed)), 0, 0, 21, 24);
		$display("test single done");
		// continuous software conversions stop when disabled
		t = doneCnt;
		bus(1'b1, CONTROL_OFS, ctl(0, 0, 4, 0, 0));
		wait_done(t + 3);
		bus(1'b1, CONTROL_OFS, 32'h0000_0000);
		repeat (60) @(posedge clk);
		t = doneCnt;
		repeat (60) @(posedge clk);
		cmp(32'(doneCnt - t), 32'h0000_0000);
		$display("test continuous done");
		// each hardware source, short pulse gives one conversion
		for (int k = 0; k < 5; k++)
		begin
			t = doneCnt;
			bus(1'b1, CONTROL_OFS, ctl(0, 2, typs[k], 0, 0));
			trig[k] <= 1'b1;
			repeat (2) @(posedge clk);
			trig[k] <= 1'b0;
			repeat (80) @(posedge clk);
			cmp(32'(doneCnt - t), 32'h0000_0001);
		end
		// pin held through two ends reruns until seen low at an end
		t = doneCnt;
		bus(1'b1, CONTROL_OFS, ctl(0, 0, 0, 0, 0));
		trig[0] <= 1'b1;
		wait_done(t + 2);
		trig[0] <= 1'b0;
		repeat (80) @(posedge clk);
		cmp(32'(doneCnt - t), 32'h0000_0003);
		$display("test triggers done");
		end_sim();
	end
endmodule // adcc_top_tb_top
`default_nettype wire
